/* common/fmsp_cfg.svh */
// Purpose: offsets, field positions, reset values and counts of the serial port
// Assumes: byte addresses on the Avalon-MM slave port
// Notes: definitions only
`ifndef FMSP_CFG_SVH
`define FMSP_CFG_SVH

`define FMSP_OFF_CTRL 5'h00
`define FMSP_OFF_STAT 5'h04
`define FMSP_OFF_TXD 5'h08
`define FMSP_OFF_RXD 5'h0C
`define FMSP_OFF_BRG 5'h10

`define FMSP_CTRL_RST 8'h00
`define FMSP_BRG_RST 10'h001

`define FMSP_STAT_RXDONE 0
`define FMSP_STAT_TXDONE 1
`define FMSP_STAT_RXB8 2
`define FMSP_STAT_TXBUSY 3
`define FMSP_STAT_RXBUSY 4
`define FMSP_STAT_FIFO_EMPTY 5

`define FMSP_M0_DIV 6
`define FMSP_OVERSAMPLE 16
`define FMSP_FIFO_DEPTH 8

`endif

/* common/fmsp_pkg.sv */
// Purpose: shared types of the serial port
// Assumes: nothing
// Notes: constants live in fmsp_cfg.svh
package fmsp_pkg;

    typedef struct packed {
        logic mode_select_high;
        logic mode_select_low;
        logic rsv5;
        logic rx_enable;
        logic tx_bit8;
        logic rate_doubling_bit;
        logic generator_select;
        logic rsv0;
    } fmsp_ctrl_t;

    typedef struct packed {
        logic tick16;
        logic m0_tick;
    } fmsp_baud_t;

    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_RUN = 1'b1
    } fmsp_tx_st_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_SHIFT = 2'b10
    } fmsp_rx_st_t;

endpackage

/* verilog/fmsp_fifo.sv */
// Purpose: transmit data fifo, valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes: out_data comes from the storage flops
`timescale 1ns/1ns
module fmsp_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != '0);
    assign out_data = mem[rptr];

    always_comb
    begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wptr = push ? wptr + 1'b1 : wptr;
        next_rptr = pop ? rptr + 1'b1 : rptr;
        next_count = count;
        if (push && !pop)
        begin
            next_count = count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end
        else
        begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wptr] <= in_data;
        end
    end
endmodule

/* verilog/fmsp_baud.sv */
// Purpose: baud clock enables for all four modes
// Assumes: timer1_ovf is a one-cycle pulse
// Notes: tick16 is the 16x baud clock, m0_tick a half bit of mode 0
`timescale 1ns/1ns
`include "fmsp_cfg.svh"
module fmsp_baud
import fmsp_pkg::*;
#(
    parameter int BRG_W = 10
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [1:0] mode,
    input wire logic rate_doubling_bit,
    input wire logic generator_select,
    input wire logic timer1_ovf,
    input wire logic [BRG_W-1:0] brg_div,
    output fmsp_baud_t baud
);
    localparam logic [1:0] M0_HALF = 2'(`FMSP_M0_DIV / 2 - 1);
    logic [1:0] m0_cnt, next_m0_cnt;
    logic [BRG_W-1:0] brg_cnt, next_brg_cnt;
    logic half, next_half;
    logic brg_ovf, src;

    always_comb
    begin
        next_m0_cnt = (m0_cnt == M0_HALF) ? 2'h0 : m0_cnt + 2'h1;
        brg_ovf = (brg_cnt + 1'b1 >= brg_div);
        next_brg_cnt = brg_ovf ? '0 : brg_cnt + 1'b1;
        // mode 2 feeds the oscillator, modes 1 and 3 timer 1 overflow or the generator overflow
        if (mode == 2'h2)
        begin
            src = 1'b1;
        end
        else
        begin
            src = generator_select ? brg_ovf : timer1_ovf;
        end
        next_half = src ? ~half : half;
        baud.tick16 = src && (rate_doubling_bit || half);
        baud.m0_tick = (m0_cnt == M0_HALF);
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            m0_cnt <= 2'h0;
            brg_cnt <= '0;
            half <= 1'b0;
        end
        else
        begin
            m0_cnt <= next_m0_cnt;
            brg_cnt <= next_brg_cnt;
            half <= next_half;
        end
    end
endmodule

/* verilog/fmsp_top.sv */
// Purpose: four-mode serial port with Avalon-MM register slave
// Assumes: rxd_in and timer1_ovf synchronous to core_clk at 20 MHz
// Notes: rxd pin is two-way in mode 0; txd_out then carries the shift clock
// Overview of operation
// - transmitter and receiver run at once, each on its own state; in mode 0 the code lets only one of them run at a time.
// - two mode bits choose shift mode, 8-bit uart, or two 9-bit uarts.
// - mode 0 moves eight bits lsb first on rxd, txd gives shift clock.
// - mode 0 bit rate is the clock divided by six.
// - mode 1 frames are ten bits on txd or rxd, variable rate.
// - mode 2 frames are eleven bits with nine data bits, fixed rate.
// - mode 3 uses the mode 2 frame at the variable rate.
// - async modes use a 16x baud clock divided by sixteen per bit.
// - modes 1 and 3 take timer 1 overflow or the own generator.
// - timer 1 path rate is overflow rate times doubling over 32.
// - generator path rate is its overflow rate times doubling over 32.
// - mode 2 rate is clock over 32, or over 16 when doubled.
//
// The implementer's own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
`include "fmsp_cfg.svh"
module fmsp_top
import fmsp_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic timer1_ovf,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic txd_out
);
    fmsp_ctrl_t ctrl, next_ctrl;
    fmsp_baud_t baud;
    logic [1:0] mode;
    logic [9:0] brg_div, next_brg_div;
    logic tx_flag, next_tx_flag, rx_flag, next_rx_flag;
    logic rd_done, next_rd_done;
    logic [31:0] next_readdata;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [7:0] fifo_data;
    logic wr_ok, tx_set, rx_set;
    fmsp_tx_st_t tx_state, next_tx_state;
    logic [10:0] tx_sh, next_tx_sh;
    logic [3:0] tx_idx, next_tx_idx, tx_sub, next_tx_sub;
    logic tx_phase, next_tx_phase, tx_line, next_tx_line, tx_clk, next_tx_clk;
    fmsp_rx_st_t rx_state, next_rx_state;
    logic [8:0] rx_sh, next_rx_sh;
    logic [3:0] rx_idx, next_rx_idx, rx_sub, next_rx_sub;
    logic rx_phase, next_rx_phase, rx_clk, next_rx_clk;
    logic [7:0] rx_data, next_rx_data;
    logic rx_b8, next_rx_b8;

    function automatic logic [3:0] frame_bits(input logic [1:0] m);
        frame_bits = (m == 2'h1) ? 4'hA : 4'hB;
    endfunction

    assign mode = {ctrl.mode_select_high, ctrl.mode_select_low};

    fmsp_baud u_baud
    (
        .core_clk(core_clk),
        .reset(reset),
        .mode(mode),
        .rate_doubling_bit(ctrl.rate_doubling_bit),
        .generator_select(ctrl.generator_select),
        .timer1_ovf(timer1_ovf),
        .brg_div(brg_div),
        .baud(baud)
    );

    fmsp_fifo #(.WIDTH(8), .DEPTH(`FMSP_FIFO_DEPTH)) u_fifo
    (
        .core_clk(core_clk),
        .reset(reset),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(avs_writedata[7:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // register slave
    assign fifo_in_valid = avs_write && avs_address == `FMSP_OFF_TXD && avs_byteenable[0];
    assign avs_waitrequest = (avs_read && !rd_done) || (fifo_in_valid && !fifo_in_ready);
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];

    always_comb
    begin
        next_ctrl = ctrl;
        next_brg_div = brg_div;
        next_tx_flag = tx_flag;
        next_rx_flag = rx_flag;
        next_rd_done = avs_read && !rd_done;
        next_readdata = avs_readdata;
        if (wr_ok && avs_address == `FMSP_OFF_CTRL)
        begin
            next_ctrl = fmsp_ctrl_t'(avs_writedata[7:0]);
        end
        if (wr_ok && avs_address == `FMSP_OFF_BRG)
        begin
            next_brg_div[7:0] = avs_writedata[7:0];
            if (avs_byteenable[1])
            begin
                next_brg_div[9:8] = avs_writedata[9:8];
            end
        end
        if (wr_ok && avs_address == `FMSP_OFF_STAT)
        begin
            if (avs_writedata[`FMSP_STAT_TXDONE])
            begin
                next_tx_flag = 1'b0;
            end
            if (avs_writedata[`FMSP_STAT_RXDONE])
            begin
                next_rx_flag = 1'b0;
            end
        end
        // a set in the clearing cycle wins
        if (tx_set)
        begin
            next_tx_flag = 1'b1;
        end
        if (rx_set)
        begin
            next_rx_flag = 1'b1;
        end
        if (avs_read && !rd_done)
        begin
            next_readdata = 32'h0000_0000;
            unique case (avs_address)
                `FMSP_OFF_CTRL: next_readdata[7:0] = ctrl;
                `FMSP_OFF_STAT:
                begin
                    next_readdata[`FMSP_STAT_RXDONE] = rx_flag;
                    next_readdata[`FMSP_STAT_TXDONE] = tx_flag;
                    next_readdata[`FMSP_STAT_RXB8] = rx_b8;
                    next_readdata[`FMSP_STAT_TXBUSY] = (tx_state != TX_IDLE);
                    next_readdata[`FMSP_STAT_RXBUSY] = (rx_state != RX_IDLE);
                    next_readdata[`FMSP_STAT_FIFO_EMPTY] = !fifo_out_valid;
                end
                `FMSP_OFF_RXD: next_readdata[7:0] = rx_data;
                `FMSP_OFF_BRG: next_readdata[9:0] = brg_div;
                default: next_readdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ctrl <= fmsp_ctrl_t'(`FMSP_CTRL_RST);
            brg_div <= `FMSP_BRG_RST;
            tx_flag <= 1'b0;
            rx_flag <= 1'b0;
            rd_done <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            ctrl <= next_ctrl;
            brg_div <= next_brg_div;
            tx_flag <= next_tx_flag;
            rx_flag <= next_rx_flag;
            rd_done <= next_rd_done;
            avs_readdata <= next_readdata;
        end
    end

    // transmitter
    always_comb
    begin
        next_tx_state = tx_state;
        next_tx_sh = tx_sh;
        next_tx_idx = tx_idx;
        next_tx_sub = tx_sub;
        next_tx_phase = tx_phase;
        next_tx_line = tx_line;
        next_tx_clk = tx_clk;
        fifo_pop = 1'b0;
        tx_set = 1'b0;
        unique case (tx_state)
            TX_IDLE:
            begin
                next_tx_line = 1'b1;
                next_tx_clk = 1'b1;
                if (mode == 2'h0)
                begin
                    if (fifo_out_valid && baud.m0_tick && rx_state == RX_IDLE)
                    begin
                        fifo_pop = 1'b1;
                        next_tx_sh = {3'h7, fifo_data};
                        next_tx_idx = 4'h0;
                        next_tx_phase = 1'b0;
                        next_tx_state = TX_RUN;
                    end
                end
                else if (fifo_out_valid && baud.tick16)
                begin
                    fifo_pop = 1'b1;
                    next_tx_sh = {1'b1, (mode == 2'h1) | ctrl.tx_bit8, fifo_data, 1'b0};
                    next_tx_line = 1'b0;
                    next_tx_idx = 4'h0;
                    next_tx_sub = 4'h0;
                    next_tx_state = TX_RUN;
                end
            end
            TX_RUN:
            begin
                if (mode == 2'h0)
                begin
                    if (baud.m0_tick)
                    begin
                        next_tx_phase = !tx_phase;
                        next_tx_clk = tx_phase;
                        if (tx_phase)
                        begin
                            next_tx_sh = {1'b1, tx_sh[10:1]};
                            next_tx_idx = tx_idx + 4'h1;
                            if (tx_idx == 4'h7)
                            begin
                                tx_set = 1'b1;
                                next_tx_state = TX_IDLE;
                            end
                        end
                    end
                end
                else if (baud.tick16)
                begin
                    next_tx_sub = tx_sub + 4'h1;
                    if (tx_sub == 4'hF)
                    begin
                        next_tx_sh = {1'b1, tx_sh[10:1]};
                        next_tx_line = tx_sh[1];
                        next_tx_idx = tx_idx + 4'h1;
                        if (tx_idx + 4'h2 == frame_bits(mode))
                        begin
                            tx_set = 1'b1;
                        end
                        if (tx_idx + 4'h1 == frame_bits(mode))
                        begin
                            next_tx_line = 1'b1;
                            next_tx_state = TX_IDLE;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            tx_state <= TX_IDLE;
            tx_sh <= 11'h7FF;
            tx_idx <= 4'h0;
            tx_sub <= 4'h0;
            tx_phase <= 1'b0;
            tx_line <= 1'b1;
            tx_clk <= 1'b1;
        end
        else
        begin
            tx_state <= next_tx_state;
            tx_sh <= next_tx_sh;
            tx_idx <= next_tx_idx;
            tx_sub <= next_tx_sub;
            tx_phase <= next_tx_phase;
            tx_line <= next_tx_line;
            tx_clk <= next_tx_clk;
        end
    end

    // receiver
    always_comb
    begin
        next_rx_state = rx_state;
        next_rx_sh = rx_sh;
        next_rx_idx = rx_idx;
        next_rx_sub = rx_sub;
        next_rx_phase = rx_phase;
        next_rx_clk = 1'b1;
        next_rx_data = rx_data;
        next_rx_b8 = rx_b8;
        rx_set = 1'b0;
        unique case (rx_state)
            RX_IDLE:
            begin
                if (mode == 2'h0)
                begin
                    if (ctrl.rx_enable && !rx_flag && tx_state == TX_IDLE && !fifo_out_valid
                        && baud.m0_tick)
                    begin
                        next_rx_idx = 4'h0;
                        next_rx_phase = 1'b0;
                        next_rx_state = RX_SHIFT;
                    end
                end
                else if (ctrl.rx_enable && baud.tick16 && !rxd_in)
                begin
                    next_rx_sub = 4'h0;
                    next_rx_state = RX_START;
                end
            end
            RX_START:
            begin
                if (baud.tick16)
                begin
                    next_rx_sub = rx_sub + 4'h1;
                    if (rx_sub == 4'h7)
                    begin
                        next_rx_sub = 4'h0;
                        next_rx_idx = 4'h0;
                        next_rx_state = rxd_in ? RX_IDLE : RX_DATA;
                    end
                end
            end
            RX_DATA:
            begin
                if (baud.tick16)
                begin
                    next_rx_sub = rx_sub + 4'h1;
                    if (rx_sub == 4'hF)
                    begin
                        next_rx_idx = rx_idx + 4'h1;
                        if (rx_idx + 4'h2 < frame_bits(mode))
                        begin
                            next_rx_sh = {rxd_in, rx_sh[8:1]};
                        end
                        else
                        begin
                            next_rx_state = RX_IDLE;
                            if (rxd_in)
                            begin
                                rx_set = 1'b1;
                                next_rx_data = (mode == 2'h1) ? rx_sh[8:1] : rx_sh[7:0];
                                next_rx_b8 = (mode == 2'h1) ? 1'b1 : rx_sh[8];
                            end
                        end
                    end
                end
            end
            RX_SHIFT:
            begin
                next_rx_clk = rx_clk;
                if (baud.m0_tick)
                begin
                    next_rx_phase = !rx_phase;
                    next_rx_clk = rx_phase;
                    if (rx_phase)
                    begin
                        next_rx_sh = {rxd_in, rx_sh[8:1]};
                        next_rx_idx = rx_idx + 4'h1;
                        if (rx_idx == 4'h7)
                        begin
                            rx_set = 1'b1;
                            next_rx_data = {rxd_in, rx_sh[8:2]};
                            next_rx_state = RX_IDLE;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rx_state <= RX_IDLE;
            rx_sh <= 9'h000;
            rx_idx <= 4'h0;
            rx_sub <= 4'h0;
            rx_phase <= 1'b0;
            rx_clk <= 1'b1;
            rx_data <= 8'h00;
            rx_b8 <= 1'b0;
        end
        else
        begin
            rx_state <= next_rx_state;
            rx_sh <= next_rx_sh;
            rx_idx <= next_rx_idx;
            rx_sub <= next_rx_sub;
            rx_phase <= next_rx_phase;
            rx_clk <= next_rx_clk;
            rx_data <= next_rx_data;
            rx_b8 <= next_rx_b8;
        end
    end

    // pins
    assign txd_out = (mode == 2'h0) ? (tx_clk & rx_clk) : tx_line;
    assign rxd_oe = (mode == 2'h0) && tx_state == TX_RUN;
    assign rxd_out = tx_sh[0];

    a_m0_clk_low: assert property (@(posedge core_clk) disable iff (reset)
        mode == 2'h0 && $past(mode) == 2'h0 && $fell(txd_out) |-> !txd_out [*3] ##1 txd_out)
        else $error("mode 0 shift clock low phase not three cycles");
    a_m0_pin_owner: assert property (@(posedge core_clk) disable iff (reset)
        rxd_oe |-> rx_state == RX_IDLE && mode == 2'h0)
        else $error("rxd driven while receiving");
    a_start_bit_low: assert property (@(posedge core_clk) disable iff (reset)
        mode != 2'h0 && tx_state == TX_RUN && tx_idx == 4'h0 |-> !txd_out)
        else $error("start bit not low");
    a_stop_bit_high: assert property (@(posedge core_clk) disable iff (reset)
        mode != 2'h0 && tx_state == TX_RUN && tx_idx + 4'h1 == frame_bits(mode) |-> txd_out)
        else $error("stop bit not high");
    a_tx_done_pos: assert property (@(posedge core_clk) disable iff (reset)
        $rose(tx_flag) && mode != 2'h0 |-> tx_idx + 4'h1 == frame_bits(mode))
        else $error("transmit flag not at stop bit");
    a_tx_edge_tick: assert property (@(posedge core_clk) disable iff (reset)
        mode != 2'h0 && $stable(mode) && $changed(tx_line) |-> $past(baud.tick16))
        else $error("transmit line moved off the baud clock");
    a_m2_double: assert property (@(posedge core_clk) disable iff (reset)
        mode == 2'h2 && ctrl.rate_doubling_bit |-> baud.tick16)
        else $error("mode 2 doubled baud clock missing");
    a_m2_half: assert property (@(posedge core_clk) disable iff (reset)
        mode == 2'h2 && !ctrl.rate_doubling_bit && $stable(ctrl) && baud.tick16 |=> !baud.tick16)
        else $error("mode 2 baud clock too fast");
    a_t1_source: assert property (@(posedge core_clk) disable iff (reset)
        mode[0] && !ctrl.generator_select && baud.tick16 |-> timer1_ovf)
        else $error("baud clock without timer 1 overflow");
    a_rx_flag_set: assert property (@(posedge core_clk) disable iff (reset)
        rx_set |=> rx_flag)
        else $error("receive flag lost");
    a_tx_indep: assert property (@(posedge core_clk) disable iff (reset)
        mode != 2'h0 && $stable(mode) && tx_state == TX_RUN && tx_sub != 4'hF |=> tx_state == TX_RUN)
        else $error("transmitter stopped early");
endmodule

/* testbench/fmsp_remote.sv */
// Purpose: remote uart and shift register peer at the serial pins
// Assumes: bit length in core_clk cycles set by the bench
// Notes: line idles high, the mark level
`timescale 1ns/1ns
module fmsp_remote
(
    input wire logic core_clk,
    input wire logic txd_out,
    input wire logic rxd_out,
    input wire logic rxd_oe,
    input wire logic m0,
    input wire logic [15:0] bitc,
    input wire logic [3:0] nbits,
    output logic line
);
    logic [10:0] got_q[$];
    logic [7:0] m0_sh, m0_out = 8'hFF;
    int m0_n = 0, m0_per = 0, m0_last = 0, cyc = 0;
    initial line = 1'b1;
    always @(posedge core_clk) cyc <= cyc + 1;
    // async frame: start, data lsb first, stop, sampled mid-bit
    always @(negedge txd_out)
    begin
        logic [10:0] w;
        w = 11'h000;
        if (!m0)
        begin
            repeat (bitc / 2) @(posedge core_clk);
            w[0] = txd_out;
            for (int i = 1; i <= nbits; i++)
            begin
                repeat (bitc) @(posedge core_clk);
                w[i] = txd_out;
            end
            got_q.push_back(w);
        end
    end
    // shift mode: data on rxd, taken or driven at falling shift clock
    always @(negedge txd_out)
    begin
        if (m0 && rxd_oe)
        begin
            m0_per = cyc - m0_last;
            m0_last = cyc;
            m0_sh = {rxd_out, m0_sh[7:1]};
            m0_n++;
            if (m0_n == 8)
            begin
                got_q.push_back({2'b00, m0_sh, 1'b0});
                m0_n = 0;
            end
        end
        else if (m0)
        begin
            line <= m0_out[0];
            m0_out <= {1'b1, m0_out[7:1]};
        end
    end
    task send(input logic [10:0] w, input int n);
        @(posedge core_clk);
        for (int i = 0; i <= n; i++)
        begin
            line <= w[i];
            repeat (bitc) @(posedge core_clk);
        end
    endtask
endmodule

/* testbench/four_mode_serial_port_tb_top.sv */
// Purpose: self-checking bench of the serial port
// Assumes: remote peer model at the serial pins
// Notes: one frame each way per setting, but ten out in the first setting, overfilling the fifo once
`timescale 1ns/1ns
`include "fmsp_cfg.svh"
module four_mode_serial_port_tb_top;
    logic core_clk = 0, reset = 1, avs_read = 0, avs_write = 0, timer1_ovf = 0, m0 = 0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, rxd_in, rxd_out, rxd_oe, txd_out, line;
    logic [15:0] bitc = 16'h0010;
    logic [3:0] nbits = 4'hA;
    logic [10:0] exp_q[$];
    logic [7:0] cfg[5] = '{8'h9C, 8'h90, 8'h56, 8'hD8, 8'h10};
    int cyc[5] = '{16, 32, 48, 64, 6};
    int seed = 32'hdba5b5e7;
    int err_count = 0;
    int tests_run = 0;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) timer1_ovf <= ~timer1_ovf;
    assign rxd_in = rxd_oe ? rxd_out : line;
    fmsp_top u_fmsp_top (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timer1_ovf(timer1_ovf), .rxd_in(rxd_in),
        .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
    fmsp_remote u_fmsp_remote (.core_clk(core_clk), .txd_out(txd_out), .rxd_out(rxd_out),
        .rxd_oe(rxd_oe), .m0(m0), .bitc(bitc), .nbits(nbits), .line(line));
    task complete_run;
        if (err_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 3000);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 3000)
            err_count++;
    endtask
    function automatic logic [10:0] frame(input logic [1:0] md, input logic b8,
        input logic [7:0] d);
        return md[1] ? {1'b1, b8, d, 1'b0} : {1'b0, md[0], d, 1'b0};
    endfunction
    initial
    begin
        logic [7:0] d, rd;
        logic r9;
        logic [1:0] md;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        bus(0, `FMSP_OFF_CTRL, 0);
        chk(q, 32'h0);
        bus(0, `FMSP_OFF_STAT, 0);
        chk(q, 32'h20);
        bus(0, 5'h14, 0);
        chk(q, 32'h0);
        for (int c = 0; c < 5; c++)
        begin
            md = cfg[c][7:6];
            bus(1, `FMSP_OFF_BRG, 32'h3);
            bus(1, `FMSP_OFF_CTRL, {24'h0, cfg[c]});
            bitc <= cyc[c];
            nbits <= md[1] ? 4'hA : 4'h9;
            m0 <= (md == 2'b00);
            rd = $random(seed);
            r9 = $random(seed);
            u_fmsp_remote.m0_out = rd;
            fork
                for (int k = 0; k < (c == 0 ? 10 : 1); k++)
                begin
                    d = $random(seed);
                    exp_q.push_back(frame(md, cfg[c][3], d));
                    bus(1, `FMSP_OFF_TXD, {24'h0, d});
                end
                if (md != 2'b00)
                    u_fmsp_remote.send(md[1] ? {1'b1, r9, rd, 1'b0} : {2'b01, rd, 1'b0},
                        md[1] ? 10 : 9);
            join
            for (int w = 0; w < 20000 && u_fmsp_remote.got_q.size() < exp_q.size(); w++)
                @(posedge core_clk);
            chk(u_fmsp_remote.got_q.size(), exp_q.size());
            while (exp_q.size() > 0 && u_fmsp_remote.got_q.size() > 0)
                chk(u_fmsp_remote.got_q.pop_front(), exp_q.pop_front());
            repeat (16 * cyc[c]) @(posedge core_clk);
            bus(0, `FMSP_OFF_STAT, 0);
            chk(q[1:0], 2'b11);
            if (md == 2'b00)
                chk(u_fmsp_remote.m0_per, 6);
            else
                chk(q[2], md[1] ? r9 : 1'b1);
            bus(0, `FMSP_OFF_RXD, 0);
            chk(q, {24'h0, rd});
            bus(1, `FMSP_OFF_STAT, 32'h3);
            bus(0, `FMSP_OFF_STAT, 0);
            chk(q[1:0], 2'b00);
        end
        complete_run;
    end
    initial
    begin
        #1000000;
        err_count++;
        complete_run;
    end
endmodule
